// *** bench/roc_meas_model.sv ***
// roc_meas_model: measurement subsystem and blocking matrix facing the stage
// assumes the bench sets the fault level, its channel and the blocking request
`timescale 1ns/10ps
module roc_meas_model #(
	parameter int TDIV = 8 // clocks per program cycle
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [19:0]      lvl,
	input  wire logic [2:0]       chan,
	input  wire logic             blk_req,
	output logic                  tick_o,
	output logic [6:0][19:0]      mag_o,
	output logic                  block_o
);
	// ****************
	// program cycle
	// ****************
	logic [7:0] div_q; // clocks within the cycle
	// free-running divider, one tick per cycle
	always_ff @(posedge clk_sys) begin
		if (reset || div_q == 8'(TDIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	assign tick_o = !reset && div_q == 8'(TDIV - 1);
	// blocking level moves only at a cycle start, a full cycle ahead of use
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			block_o <= 1'b0;
		end else if (tick_o) begin
			block_o <= blk_req;
		end
	end
	// only the chosen channel carries the fault, the others read zero
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			mag_o[i] = (chan == 3'(i)) ? lvl : 20'h00000;
		end
	end
endmodule

// *** bench/roc_stage_assertions.sv ***
// roc_stage_assertions: port-level checks of the residual overcurrent stage
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
module roc_stage_chk #(
	parameter int MW = 20,
	parameter int CW = 16
) (
	input wire logic          clk_sys,
	input wire logic          reset,
	input wire logic          tick_i,
	input wire logic [MW-1:0] coarse_rms_i,
	input wire logic [MW-1:0] coarse_trms_i,
	input wire logic [MW-1:0] coarse_pp_i,
	input wire logic [MW-1:0] sens_rms_i,
	input wire logic [MW-1:0] sens_trms_i,
	input wire logic [MW-1:0] sens_pp_i,
	input wire logic [MW-1:0] calc_fund_i,
	input wire logic [MW-1:0] harm2_i,
	input wire logic          block_i,
	input wire logic          force_en_i,
	input wire logic [3:0]    addr_i,
	input wire logic          rd_i,
	input wire logic [31:0]   rdata_o,
	input wire logic          start_o,
	input wire logic          trip_o,
	input wire logic          blocked_o
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic nf; // forcing off in the current cycle
	assign nf = !force_en_i;
	AST_ONEHOT: assert property ($onehot0({start_o, trip_o, blocked_o}))
		else $error("more than one status output high");
	AST_HOLD: assert property ($changed({start_o, trip_o, blocked_o}) && nf
		&& !$past(force_en_i) && !$past(force_en_i, 2) |-> $past(tick_i, 2))
		else $error("status moved without a program cycle");
	AST_START_CAUSE: assert property ($rose(start_o) && nf && !$past(force_en_i, 2)
		|-> $past(tick_i, 2) && !$past(block_i, 2))
		else $error("start raised without an unblocked cycle");
	AST_BLOCK_CLEARS: assert property (tick_i && block_i && nf |=> ##1 !start_o && !trip_o)
		else $error("blocking left start or trip standing");
	AST_BLOCKED_CAUSE: assert property ($rose(blocked_o) && nf && !$past(force_en_i, 2)
		|-> $past(block_i, 2) || $past(harm2_i, 2) != '0)
		else $error("blocked shown with no blocking cause");
	AST_TRIP_FROM_START: assert property ($rose(trip_o) && nf && !$past(force_en_i, 2)
		|-> $past(start_o))
		else $error("trip without a preceding start");
	AST_NO_PICK: assert property (tick_i && nf && coarse_rms_i == '0 && coarse_trms_i == '0
		&& coarse_pp_i == '0 && sens_rms_i == '0 && sens_trms_i == '0 && sens_pp_i == '0
		&& calc_fund_i == '0 |=> ##1 !start_o)
		else $error("start held with zero measurement");
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == '0)
		else $error("read data outside the read answer cycle");
	AST_UNMAPPED: assert property ($past(rd_i) && $past(addr_i) > 4'hd |-> rdata_o == '0)
		else $error("unmapped read returned data");
	COV_START: cover property ($rose(start_o));
	COV_TRIP: cover property ($rose(trip_o));
	COV_BLOCKED: cover property ($rose(blocked_o));
endmodule
bind roc_stage roc_stage_chk #(.MW(MW), .CW(CW)) chk_u (.clk_sys(clk_sys), .reset(reset),
	.tick_i(tick_i), .coarse_rms_i(coarse_rms_i), .coarse_trms_i(coarse_trms_i),
	.coarse_pp_i(coarse_pp_i), .sens_rms_i(sens_rms_i), .sens_trms_i(sens_trms_i),
	.sens_pp_i(sens_pp_i), .calc_fund_i(calc_fund_i),
	.harm2_i(harm2_i), .block_i(block_i), .force_en_i(force_en_i), .addr_i(addr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .start_o(start_o), .trip_o(trip_o),
	.blocked_o(blocked_o));

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for the residual overcurrent stage
// assumes the measurement model ticks every eight clocks
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic clk_sys = 1'b0, reset = 1'b1, tick, blk_req = 1'b0, block;
	logic force_en = 1'b0, volt = 1'b0, comm_wr = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic [19:0] lvl = '0, h2 = '0, comm_pick = '0;
	logic [2:0] chan = '0;
	logic [1:0] fphase = '0;
	logic frev = 1'b0;
	logic [16:0] ang_r = '0, ang_u = '0, ang_i = '0;
	logic [6:0][19:0] mag;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic start_o, trip_o, blocked_o;
	int error_cnt = 0, checked = 0;
	always #5 clk_sys = !clk_sys;
	roc_meas_model part_u (.clk_sys(clk_sys), .reset(reset), .lvl(lvl), .chan(chan),
		.blk_req(blk_req), .tick_o(tick), .mag_o(mag), .block_o(block));
	roc_stage dut_u (.clk_sys(clk_sys), .reset(reset), .tick_i(tick),
		.coarse_rms_i(mag[0]), .coarse_trms_i(mag[1]), .coarse_pp_i(mag[2]),
		.sens_rms_i(mag[3]), .sens_trms_i(mag[4]), .sens_pp_i(mag[5]),
		.calc_fund_i(mag[6]), .harm2_i(h2), .fund_i(lvl), .block_i(block),
		.force_en_i(force_en), .res_angle_i(ang_r), .u1_angle_i(ang_u), .i1_angle_i(ang_i),
		.volt_avail_i(volt), .fault_phase_i(fphase), .fault_rev_i(frev), .comm_wr_i(comm_wr),
		.comm_pick_i(comm_pick), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
		.rdata_o(rdata), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));
	// ****************
	// access tasks
	// ****************
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic meas(input logic [19:0] l, input logic b);
		@(posedge clk_sys);
		lvl <= l;
		blk_req <= b;
	endtask
	// wait n program cycles, then let the outputs settle
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys iff tick);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic comm(input logic [19:0] v);
		@(posedge clk_sys);
		comm_pick <= v;
		comm_wr <= 1'b1;
		@(posedge clk_sys);
		comm_wr <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run of about a thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish;
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		rd(roc_pkg::A_CTRL); `CHK(d, 32'h0)
		rd(roc_pkg::A_PICK); `CHK(d, 32'h2ee0)
		rd(roc_pkg::A_HARM); `CHK(d, 32'h1)
		rd(4'hf); `CHK(d, 32'h0)
		wr(roc_pkg::A_OPDL, 32'h64);
		wr(roc_pkg::A_PICK, 32'h2710);
		// every source and magnitude; calc ignores the magnitude choice
		for (int i = 0; i < 7; i++) begin
			wr(roc_pkg::A_CTRL, {28'h0, (i == 6) ? 2'h2 : 2'(i % 3), 2'((i < 3) ? 0 : (i < 6) ? 1 : 2)});
			chan <= 3'(i);
			meas(20'h02711, 1'b0);
			ticks(2); `CHK(start_o, 1'b1)
			meas(20'h00000, 1'b0);
			ticks(2); `CHK(start_o, 1'b0)
		end
		wr(roc_pkg::A_CTRL, 32'h0);
		chan <= 3'h0;
		// pick-up edge and 97 percent release edge
		for (int i = 0; i < 4; i++) begin
			meas((i == 0) ? 20'h02710 : (i == 1) ? 20'h02711 : (i == 2) ? 20'h025e4 : 20'h025e3, 1'b0);
			ticks(2); `CHK(start_o, (i == 1 || i == 2))
		end
		meas(20'h04e20, 1'b0);
		ticks(2);
		rd(roc_pkg::A_RATIO); `CHK(d, 32'hc8)
		rd(roc_pkg::A_STAT); `CHK(d[2:0], 3'h5)
		wr(roc_pkg::A_PICK, 32'h7530);
		ticks(2); `CHK(start_o, 1'b0)
		// level low across a whole cycle so the trip count starts from zero
		meas(20'h00000, 1'b0);
		wr(roc_pkg::A_PICK, 32'h2710);
		wr(roc_pkg::A_OPDL, 32'h3);
		fphase <= 2'h2;
		frev <= 1'b1;
		ticks(1);
		meas(20'h04e20, 1'b0);
		ticks(2); `CHK({start_o, trip_o}, 2'b10)
		ticks(2); `CHK(trip_o, 1'b1)
		rd(roc_pkg::A_STAT); `CHK(d[6:4], 3'h4)
		meas(20'h00000, 1'b0);
		ticks(2);
		wr(roc_pkg::A_OPDL, 32'h6);
		meas(20'h04e20, 1'b0);
		ticks(2); `CHK(start_o, 1'b1)
		meas(20'h04e20, 1'b1);
		ticks(8); `CHK({start_o, trip_o}, 2'b00)
		meas(20'h00000, 1'b1);
		ticks(2);
		meas(20'h04e20, 1'b1);
		ticks(8); `CHK({start_o, trip_o, blocked_o}, 3'b001)
		meas(20'h00000, 1'b0);
		ticks(3); `CHK(blocked_o, 1'b0)
		// inrush block at 25 percent against a 10 percent limit
		wr(roc_pkg::A_HARM, 32'h3e8);
		wr(roc_pkg::A_CTRL, 32'h10);
		h2 <= 20'h01388;
		meas(20'h04e20, 1'b0);
		ticks(2); `CHK({start_o, blocked_o}, 2'b01)
		meas(20'h00000, 1'b0);
		ticks(2);
		wr(roc_pkg::A_CTRL, 32'h0);
		meas(20'h04e20, 1'b0);
		ticks(2); `CHK(start_o, 1'b1)
		meas(20'h00000, 1'b0);
		h2 <= 20'h00000;
		ticks(2);
		comm(20'h01388);
		rd(roc_pkg::A_PICK); `CHK(d, 32'h2710)
		wr(roc_pkg::A_CTRL, 32'h20);
		comm(20'h01388);
		rd(roc_pkg::A_PICK); `CHK(d, 32'h1388)
		ang_r <= 17'h01388;
		ang_u <= 17'h003e8;
		ang_i <= 17'h00bb8;
		volt <= 1'b1;
		ticks(1);
		rd(roc_pkg::A_ANGL); `CHK(d, 32'hfa0)
		volt <= 1'b0;
		ticks(1);
		rd(roc_pkg::A_ANGL); `CHK(d, 32'h7d0)
		// inverse time: ratio 3.00, k 400 gives 200 steps, above the definite floor of 6
		wr(roc_pkg::A_KFAC, 32'h190);
		wr(roc_pkg::A_CTRL, 32'h100);
		meas(20'h03a98, 1'b0);
		ticks(2);
		rd(roc_pkg::A_EXPT); `CHK(d, 32'hc8)
		rd(roc_pkg::A_RATIO); `CHK(d, 32'h12c)
		rd(roc_pkg::A_TREM); `CHK((d > 32'h0) && (d < 32'hc8), 1'b1)
		meas(20'h00000, 1'b0);
		ticks(2);
		// forced status walk, counters cleared first
		wr(roc_pkg::A_CTRL, 32'h200);
		force_en <= 1'b1;
		for (int f = 1; f < 5; f++) begin
			wr(roc_pkg::A_CTRL, 32'(f % 4) << 6);
			ticks(1); `CHK({start_o, trip_o, blocked_o}, (f == 4) ? 3'b000 : 3'b100 >> (f - 1))
			rd(roc_pkg::A_STAT); `CHK(d[1:0], 2'(f % 4))
		end
		force_en <= 1'b0;
		for (int c = 0; c < 3; c++) begin
			rd(4'(roc_pkg::A_CSTA + c)); `CHK(d, 32'h1)
		end
		wr(roc_pkg::A_CTRL, 32'h200);
		rd(roc_pkg::A_CSTA); `CHK(d, 32'h0)
		tally_and_finish;
	end
endmodule

// *** logic/roc_pkg.sv ***
// roc_pkg: constants for the residual overcurrent stage
// assumes one program-cycle tick per time step
package roc_pkg;
	// ****************
	// register indexes
	// ****************
	localparam logic [3:0] A_CTRL  = 4'h0;
	localparam logic [3:0] A_PICK  = 4'h1;
	localparam logic [3:0] A_HARM  = 4'h2;
	localparam logic [3:0] A_OPDL  = 4'h3;
	localparam logic [3:0] A_RLDL  = 4'h4;
	localparam logic [3:0] A_KFAC  = 4'h5;
	localparam logic [3:0] A_STAT  = 4'h6;
	localparam logic [3:0] A_ANGL  = 4'h7;
	localparam logic [3:0] A_EXPT  = 4'h8;
	localparam logic [3:0] A_TREM  = 4'h9;
	localparam logic [3:0] A_RATIO = 4'ha;
	localparam logic [3:0] A_CSTA  = 4'hb;
	localparam logic [3:0] A_CTRP  = 4'hc;
	localparam logic [3:0] A_CBLK  = 4'hd;
	// ****************
	// control fields
	// ****************
	localparam int F_SRC   = 0; // 2 bits
	localparam int F_MAG   = 2; // 2 bits
	localparam int F_INR   = 4;
	localparam int F_REM   = 5;
	localparam int F_FRC   = 6; // 2 bits
	localparam int F_IDMT  = 8;
	localparam int F_CLR   = 9;
	// ****************
	// encodings
	// ****************
	localparam logic [1:0] SRC_COARSE = 2'h0;
	localparam logic [1:0] SRC_SENS   = 2'h1;
	localparam logic [1:0] SRC_CALC   = 2'h2;
	localparam logic [1:0] MAG_RMS    = 2'h0;
	localparam logic [1:0] MAG_TRMS   = 2'h1;
	localparam logic [1:0] MAG_PP     = 2'h2;
	typedef enum logic [1:0] {
		ST_NORMAL  = 2'b00,
		ST_START   = 2'b01,
		ST_TRIP    = 2'b10,
		ST_BLOCKED = 2'b11
	} roc_state_t;
	// ****************
	// scales and resets
	// ****************
	localparam logic [19:0] PICK_RST  = 20'h02ee0; // 1.2000 in 0.0001 In
	localparam logic [12:0] HARM_RST  = 13'h0001;  // 0.01 %
	localparam logic [31:0] HYST_NUM  = 32'h61;    // 97
	localparam logic [31:0] PCT       = 32'h64;    // 100
	localparam logic [31:0] HARM_FULL = 32'h2710;  // 10000 = 100.00 %
	localparam logic [31:0] RATIO_MAX = 32'h1e848; // 1250.00
	localparam logic [18:0] TIME_MAX  = 19'h57e40; // 1800 s in 5 ms
	localparam int          STEP_MS   = 5;         // time resolution
	localparam logic [17:0] ANG_FULL  = 18'h08ca0; // 360.00 deg
endpackage

// *** logic/roc_stage.sv ***
// roc_stage: non-directional residual overcurrent stage
// assumes tick_i pulses once per program cycle (one 5 ms step)
// and measurements are stable when tick_i is high
`timescale 1ns/10ps
module roc_stage #(
	parameter int MW = 20, // magnitude width, 0.0001 In
	parameter int CW = 16  // counter width
) (
	input  wire logic          clk_sys,
	input  wire logic          reset,
	input  wire logic          tick_i,
	input  wire logic [MW-1:0] coarse_rms_i,
	input  wire logic [MW-1:0] coarse_trms_i,
	input  wire logic [MW-1:0] coarse_pp_i,
	input  wire logic [MW-1:0] sens_rms_i,
	input  wire logic [MW-1:0] sens_trms_i,
	input  wire logic [MW-1:0] sens_pp_i,
	input  wire logic [MW-1:0] calc_fund_i,
	input  wire logic [MW-1:0] harm2_i,
	input  wire logic [MW-1:0] fund_i,
	input  wire logic          block_i,
	input  wire logic          force_en_i,
	input  wire logic [16:0]   res_angle_i,
	input  wire logic [16:0]   u1_angle_i,
	input  wire logic [16:0]   i1_angle_i,
	input  wire logic          volt_avail_i,
	input  wire logic [1:0]    fault_phase_i,
	input  wire logic          fault_rev_i,
	input  wire logic          comm_wr_i,
	input  wire logic [19:0]   comm_pick_i,
	input  wire logic [3:0]    addr_i,
	input  wire logic [31:0]   wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [31:0]   rdata_o,
	output logic               start_o,
	output logic               trip_o,
	output logic               blocked_o
);
	// ****************
	// settings
	// ****************
	logic [9:0]    ctrl_q;   // control word
	logic [19:0]   pick_q;   // threshold
	logic [12:0]   harm_q;   // inrush limit
	logic [18:0]   opdl_q;   // definite delay, steps
	logic [18:0]   rldl_q;   // release delay, steps
	logic [15:0]   kfac_q;   // inverse time factor
	// ****************
	// state
	// ****************
	roc_pkg::roc_state_t st_q;  // computed state
	roc_pkg::roc_state_t shown; // state after forcing
	logic          blk_q;    // sampled blocking
	logic          pick_on_q;// pick-up with hysteresis
	logic [18:0]   elap_q;   // operate time elapsed
	logic [18:0]   rel_q;    // release time left
	logic [18:0]   expt_q;   // expected time
	logic [18:0]   trem_q;   // time remaining
	logic [16:0]   ratio_q;  // ratio, 0.01
	logic [16:0]   ang_q;    // angle, 0.01 deg
	logic [2:0]    ftype_q;  // previous fault type
	logic [CW-1:0] cnt_q [3];// start, trip, blocked
	logic [MW-1:0] meas;     // selected magnitude
	logic          inrush;   // harmonic block
	logic          blk_now;  // total blocking
	logic          over;     // above threshold
	logic          under;    // below release level
	logic          pick_now; // pick-up this cycle
	logic [31:0]   ratio_w;  // raw ratio
	logic [31:0]   inv_w;    // raw inverse time
	logic [18:0]   exp_now;  // expected time now
	logic          wr_ctrl;  // control write
	logic          clr_cnt;  // counter clear
	logic [17:0]   ang_raw;  // raw difference
	logic [2:0]    hit;      // counter events

	// ****************
	// measurement select
	// ****************
	// magnitude choice ignored for computed source
	always_comb begin
		unique case (ctrl_q[roc_pkg::F_SRC +: 2])
			roc_pkg::SRC_SENS: begin
				unique case (ctrl_q[roc_pkg::F_MAG +: 2])
					roc_pkg::MAG_TRMS: meas = sens_trms_i;
					roc_pkg::MAG_PP:   meas = sens_pp_i;
					default:           meas = sens_rms_i;
				endcase
			end
			roc_pkg::SRC_CALC: meas = calc_fund_i;
			default: begin
				unique case (ctrl_q[roc_pkg::F_MAG +: 2])
					roc_pkg::MAG_TRMS: meas = coarse_trms_i;
					roc_pkg::MAG_PP:   meas = coarse_pp_i;
					default:           meas = coarse_rms_i;
				endcase
			end
		endcase
	end

	// ****************
	// comparisons
	// ****************
	// over threshold, and release below 97 percent
	assign over  = 32'(meas) > 32'(pick_q);
	assign under = 32'(meas) * roc_pkg::PCT
		< 32'(pick_q) * roc_pkg::HYST_NUM;
	assign pick_now = pick_on_q ? !under : over;
	// harmonic ratio above limit, if enabled
	assign inrush = ctrl_q[roc_pkg::F_INR]
		&& 64'(harm2_i) * 64'(roc_pkg::HARM_FULL)
		> 64'(harm_q) * 64'(fund_i);
	assign blk_now = block_i | inrush;

	// ratio in 0.01 steps, clamped
	always_comb begin
		ratio_w = roc_pkg::RATIO_MAX;
		if (pick_q != 20'h0) begin
			ratio_w = (32'(meas) * roc_pkg::PCT) / 32'(pick_q);
		end
		if (ratio_w > roc_pkg::RATIO_MAX) begin
			ratio_w = roc_pkg::RATIO_MAX;
		end
	end

	// inverse time k*100/(ratio-100), floor at definite delay
	always_comb begin
		inv_w = 32'(roc_pkg::TIME_MAX);
		if (ratio_w > roc_pkg::PCT) begin
			inv_w = (32'(kfac_q) * roc_pkg::PCT) / (ratio_w - roc_pkg::PCT);
		end
		if (inv_w > 32'(roc_pkg::TIME_MAX)) begin
			inv_w = 32'(roc_pkg::TIME_MAX);
		end
		if (inv_w < 32'(opdl_q)) begin
			inv_w = 32'(opdl_q);
		end
		exp_now = ctrl_q[roc_pkg::F_IDMT] ? inv_w[18:0] : opdl_q;
	end

	// ****************
	// register writes
	// ****************
	assign wr_ctrl = wr_i && addr_i == roc_pkg::A_CTRL;
	assign clr_cnt = wr_ctrl && wdata_i[roc_pkg::F_CLR];

	// settings take effect at the next cycle, no restart
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_q <= 10'h0;
			harm_q <= roc_pkg::HARM_RST;
			opdl_q <= 19'h0;
			rldl_q <= 19'h0;
			kfac_q <= 16'h0;
		end else if (wr_i) begin
			unique case (addr_i)
				roc_pkg::A_CTRL: ctrl_q <= {1'b0, wdata_i[8:0]};
				roc_pkg::A_HARM: harm_q <= wdata_i[12:0];
				roc_pkg::A_OPDL: opdl_q <= wdata_i[18:0];
				roc_pkg::A_RLDL: rldl_q <= wdata_i[18:0];
				roc_pkg::A_KFAC: kfac_q <= wdata_i[15:0];
				default: ;
			endcase
		end
	end

	// threshold: local writes always, remote only if allowed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pick_q <= roc_pkg::PICK_RST;
		end else if (wr_i && addr_i == roc_pkg::A_PICK) begin
			pick_q <= wdata_i[19:0];
		end else if (comm_wr_i && ctrl_q[roc_pkg::F_REM]) begin
			pick_q <= comm_pick_i;
		end
	end

	// ****************
	// stage sequence
	// ****************
	// blocking and pick-up latched at the cycle start
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			blk_q     <= 1'b0;
			pick_on_q <= 1'b0;
		end else if (tick_i) begin
			blk_q     <= blk_now;
			pick_on_q <= pick_now;
		end
	end

	// state steps only on the tick
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= roc_pkg::ST_NORMAL;
		end else if (tick_i) begin
			unique case (st_q)
				roc_pkg::ST_NORMAL: begin
					if (pick_now && blk_now) begin
						st_q <= roc_pkg::ST_BLOCKED;
					end else if (pick_now) begin
						st_q <= roc_pkg::ST_START;
					end
				end
				roc_pkg::ST_START: begin
					if (!pick_now || blk_now) begin
						st_q <= roc_pkg::ST_NORMAL;
					end else if (elap_q + 19'h1 >= exp_now) begin
						st_q <= roc_pkg::ST_TRIP;
					end
				end
				roc_pkg::ST_TRIP: begin
					if (!pick_now || blk_now) begin
						st_q <= roc_pkg::ST_NORMAL;
					end
				end
				roc_pkg::ST_BLOCKED: begin
					// stay until pick-up drops
					if (!pick_now) begin
						st_q <= roc_pkg::ST_NORMAL;
					end
				end
			endcase
		end
	end

	// elapsed operate time with release delay
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			elap_q <= 19'h0;
			rel_q  <= 19'h0;
		end else if (tick_i) begin
			if (st_q == roc_pkg::ST_START && pick_now && !blk_now) begin
				elap_q <= elap_q + 19'h1;
				rel_q  <= rldl_q;
			end else if (st_q == roc_pkg::ST_NORMAL && pick_now && !blk_now) begin
				elap_q <= elap_q + 19'h1;
			end else if (rel_q != 19'h0 && st_q != roc_pkg::ST_TRIP) begin
				rel_q  <= rel_q - 19'h1;
			end else begin
				elap_q <= 19'h0;
				rel_q  <= 19'h0;
			end
		end
	end

	// time figures shown each cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			expt_q  <= 19'h0;
			trem_q  <= 19'h0;
			ratio_q <= 17'h0;
		end else if (tick_i) begin
			expt_q  <= exp_now;
			ratio_q <= ratio_w[16:0];
			if (st_q == roc_pkg::ST_START && exp_now > elap_q) begin
				trem_q <= exp_now - elap_q;
			end else begin
				trem_q <= 19'h0;
			end
		end
	end

	// angle against reference, wrapped to +-360 deg
	assign ang_raw = {res_angle_i[16], res_angle_i}
		- (volt_avail_i ? {u1_angle_i[16], u1_angle_i}
		: {i1_angle_i[16], i1_angle_i});
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ang_q <= 17'h0;
		end else if (tick_i) begin
			if ($signed(ang_raw) > $signed(roc_pkg::ANG_FULL)) begin
				ang_q <= 17'(ang_raw - roc_pkg::ANG_FULL);
			end else if ($signed(ang_raw) < -$signed(roc_pkg::ANG_FULL)) begin
				ang_q <= 17'(ang_raw + roc_pkg::ANG_FULL);
			end else begin
				ang_q <= ang_raw[16:0];
			end
		end
	end

	// fault type latched on trip: phase*2 - forward
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ftype_q <= 3'h0;
		end else if (tick_i && st_q == roc_pkg::ST_START
			&& pick_now && !blk_now && elap_q + 19'h1 >= exp_now
			&& fault_phase_i != 2'h0) begin
			ftype_q <= {fault_phase_i, 1'b0} - {2'h0, !fault_rev_i};
		end
	end

	// ****************
	// outputs
	// ****************
	// forced status overrides computed state
	assign shown = force_en_i
		? roc_pkg::roc_state_t'(ctrl_q[roc_pkg::F_FRC +: 2]) : st_q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			start_o   <= 1'b0;
			trip_o    <= 1'b0;
			blocked_o <= 1'b0;
		end else begin
			start_o   <= shown == roc_pkg::ST_START;
			trip_o    <= shown == roc_pkg::ST_TRIP;
			blocked_o <= shown == roc_pkg::ST_BLOCKED;
		end
	end

	// ****************
	// event counters
	// ****************
	// counts entries into start, trip, blocked; clear with a same-cycle entry leaves one
	assign hit[0] = start_o == 1'b0 && shown == roc_pkg::ST_START;
	assign hit[1] = trip_o == 1'b0 && shown == roc_pkg::ST_TRIP;
	assign hit[2] = blocked_o == 1'b0 && shown == roc_pkg::ST_BLOCKED;
	for (genvar i = 0; i < 3; i++) begin : g_cnt
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				cnt_q[i] <= '0;
			end else if (clr_cnt) begin
				cnt_q[i] <= CW'(hit[i]);
			end else if (hit[i] && cnt_q[i] != '1) begin
				cnt_q[i] <= cnt_q[i] + CW'(1);
			end
		end
	end

	// ****************
	// register reads
	// ****************
	// data only in the cycle after the strobe, else zero
	always_ff @(posedge clk_sys) begin
		if (reset || !rd_i) begin
			rdata_o <= 32'h0;
		end else begin
			unique case (addr_i)
				roc_pkg::A_CTRL:  rdata_o <= {23'h0, ctrl_q[8:0]};
				roc_pkg::A_PICK:  rdata_o <= {12'h0, pick_q};
				roc_pkg::A_HARM:  rdata_o <= {19'h0, harm_q};
				roc_pkg::A_OPDL:  rdata_o <= {13'h0, opdl_q};
				roc_pkg::A_RLDL:  rdata_o <= {13'h0, rldl_q};
				roc_pkg::A_KFAC:  rdata_o <= {16'h0, kfac_q};
				roc_pkg::A_STAT:  rdata_o <= {25'h0, ftype_q, blk_q,
					pick_on_q, shown};
				roc_pkg::A_ANGL:  rdata_o <= {{15{ang_q[16]}}, ang_q};
				roc_pkg::A_EXPT:  rdata_o <= {13'h0, expt_q};
				roc_pkg::A_TREM:  rdata_o <= {13'h0, trem_q};
				roc_pkg::A_RATIO: rdata_o <= {15'h0, ratio_q};
				roc_pkg::A_CSTA:  rdata_o <= 32'(cnt_q[0]);
				roc_pkg::A_CTRP:  rdata_o <= 32'(cnt_q[1]);
				roc_pkg::A_CBLK:  rdata_o <= 32'(cnt_q[2]);
				default:          rdata_o <= 32'h0;
			endcase
		end
	end
endmodule
